// [inc/pac_pkg.sv]
// constants, types and register map of the port autoneg/crossover/address block
// assumes a 25 MHz system clock and a clause 22 style management frame
package pac_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_KHZ    = 25000;          // system clock rate
  localparam int BREAK_MS   = 1500;           // break-link interval
  localparam int AN_MAX_MS  = 3000;           // longest negotiation attempt
  localparam int XO_MS      = 62;             // crossover dwell per try
  localparam int BREAK_CYC  = BREAK_MS * CLK_KHZ;
  localparam int AN_MAX_CYC = AN_MAX_MS * CLK_KHZ;
  localparam int XO_CYC     = XO_MS * CLK_KHZ;
  localparam int STRAP_WAIT = 4;              // edges after release before capture

  // ------------------------------------------------------------
  // register map (management register index)
  // ------------------------------------------------------------
  localparam logic [4:0] REG_BMC   = 5'h00;   // basic_mode_control
  localparam logic [4:0] REG_BMS   = 5'h01;   // basic mode status
  localparam logic [4:0] REG_LPA   = 5'h05;   // partner_ability_reg
  localparam logic [4:0] REG_ANX   = 5'h06;   // negotiation expansion
  localparam logic [4:0] REG_PCS   = 5'h16;   // pcs_sublayer_config
  localparam logic [4:0] REG_PHYC  = 5'h19;   // phy_control
  localparam logic [4:0] REG_PHYC2 = 5'h1C;   // phy_control_second

  // field positions
  localparam int BMC_ISO     = 10;
  localparam int BMC_AN_EN   = 12;
  localparam int BMC_RESTART = 9;
  localparam int BMS_AN_DONE = 5;
  localparam int BMS_AN_ABLE = 3;
  localparam int BMS_LINK    = 2;
  localparam int ANX_PD_FLT  = 4;
  localparam int ANX_LP_ABLE = 0;
  localparam int PCS_FXO_EN  = 15;            // forced-mode crossover enable
  localparam int PHYC_AUTOX  = 15;
  localparam int PHYC_FORCEX = 14;
  localparam int PHYC2_BCAST = 11;

  // reset values and fixed codes
  localparam logic [15:0] BMC_RST   = 16'h1000;
  localparam logic [15:0] PCS_RST   = 16'h0000;
  localparam logic [15:0] PHYC_RST  = 16'h8001;
  localparam logic [15:0] PHYC2_RST = 16'h0000;
  localparam logic [15:0] LP_PD100  = 16'h0081;
  localparam logic [15:0] LP_PD10   = 16'h0021;
  localparam logic [4:0]  ADDR_DFLT = 5'h01;
  localparam logic [4:0]  ADDR_ISO  = 5'h00;
  localparam logic [4:0]  ADDR_BC   = 5'h1F;
  localparam logic [1:0]  OP_RD     = 2'h2;
  localparam logic [1:0]  OP_WR     = 2'h1;
  localparam logic [5:0]  PRE_MIN   = 6'h20;  // preamble ones needed
  localparam logic [3:0]  HDR_LAST  = 4'hC;
  localparam logic [3:0]  DAT_LAST  = 4'hF;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    AN_OFF  = 4'h1,
    AN_BRK  = 4'h2,
    AN_NEG  = 4'h4,
    AN_DONE = 4'h8
  } pac_an_state_type;

  typedef enum logic [3:0] {
    MF_PRE = 4'h1,
    MF_HDR = 4'h2,
    MF_TA  = 4'h4,
    MF_DAT = 4'h8
  } pac_mf_state_type;

  typedef struct packed {
    logic [15:0] flp_word;   // partner base page
    logic        flp_done;   // flp exchange finished
    logic        flp_seen;   // flp bursts present
    logic        link100;    // 100 Mb/s receiver link good
    logic        link10;     // 10 Mb/s receiver link good
  } pac_pmd_type;

  typedef struct packed {
    logic quiet;     // stop tx data and link pulses
    logic send_flp;  // transmit flp bursts
    logic crossed;   // mdix pair assignment
    logic tx_take;   // accept mii transmit data
    logic mii_oe;    // drive mii outputs
  } pac_media_type;

endpackage

// [hdl/pac_port_ctl.sv]
// port control: negotiation sequencing, parallel detect reporting,
// crossover, strapped address, isolate and management register access
// assumes pmd status on sys_clk and mdc/mdio/straps from pins
`timescale 1ns/1ps
`default_nettype none
module pac_port_ctl
  import pac_pkg::*;
#(
  parameter int BRK_CYCLES = BREAK_CYC,
  parameter int NEG_CYCLES = AN_MAX_CYC,
  parameter int XO_CYCLES  = XO_CYC
)(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  // strap pins
  input  wire logic [4:0]    strap_port_address,
  input  wire logic          strap_an_enable,
  // management pins
  input  wire logic          mdc,
  input  wire logic          mdio_in,
  output logic               mdio_out,
  output logic               mdio_oe,
  // media side
  input  wire pac_pmd_type   pmd,
  output pac_media_type      media
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] s1, s2, s3, pin;
  // three stages; a change counts when stages two and three agree
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1  <= 8'h00;
      s2  <= 8'h00;
      s3  <= 8'h00;
      pin <= 8'h00;
    end
    else
    begin
      s1  <= {mdc, mdio_in, strap_an_enable, strap_port_address};
      s2  <= s1;
      s3  <= s2;
      pin <= (s2 & s3) | (pin & (s2 ^ s3));
    end
  end

  logic mdc_q;
  logic mdc_rise;
  logic din;
  assign din      = pin[6];
  assign mdc_rise = pin[7] & ~mdc_q;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [15:0] bmc, pcs, phyc, phyc2, lpa;
  logic        lp_able, pd_fault, an_armed;
  logic [2:0]  cap_cnt;
  logic        cap_done, cap_now;
  logic        wr_stb, rd_stb;
  logic [15:0] wr_data;
  logic [12:0] hdr;
  pac_an_state_type an_state;
  logic        an_go;

  // capture once the synced straps have settled; nothing negotiates before it
  assign cap_now = ~cap_done & (cap_cnt == 3'(STRAP_WAIT));
  assign an_go   = bmc[BMC_AN_EN] & an_armed & cap_done;

  // strap capture some edges after reset release
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cap_cnt  <= 3'h0;
      cap_done <= 1'b0;
      mdc_q    <= 1'b0;
    end
    else
    begin
      mdc_q <= pin[7];
      if (!cap_done)
        cap_cnt <= cap_cnt + 3'h1;
      if (cap_now)
        cap_done <= 1'b1;
    end
  end

  // basic mode control, isolate and negotiation enable
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bmc      <= BMC_RST;
      an_armed <= 1'b1;
    end
    else if (cap_now)
    begin
      bmc[BMC_AN_EN] <= pin[5];
      an_armed       <= pin[5];
      bmc[BMC_ISO]   <= (pin[4:0] == ADDR_ISO);
    end
    else
    begin
      bmc[BMC_RESTART] <= 1'b0;                          // self clearing
      if (wr_stb && hdr[4:0] == REG_BMC)
      begin
        bmc <= wr_data;
        if (!wr_data[BMC_AN_EN])
          an_armed <= 1'b1;
      end
    end
  end

  // pcs, phy control and second phy control
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pcs   <= PCS_RST;
      phyc  <= PHYC_RST;
      phyc2 <= PHYC2_RST;
    end
    else if (cap_now)
      phyc[4:0] <= pin[4:0];
    else if (wr_stb)
    begin
      if (hdr[4:0] == REG_PCS)
        pcs <= wr_data;
      if (hdr[4:0] == REG_PHYC)
        phyc <= wr_data;
      if (hdr[4:0] == REG_PHYC2)
        phyc2 <= wr_data;
    end
  end

  // read mux
  function automatic logic [15:0] rd_mux(input logic [4:0] ra);
    logic [15:0] v;
    v = 16'h0000;
    unique case (ra)
      REG_BMC:   v = bmc;
      REG_BMS:
      begin
        v[BMS_AN_DONE] = (an_state == AN_DONE);
        v[BMS_AN_ABLE] = 1'b1;
        v[BMS_LINK]    = pmd.link10 | pmd.link100;
      end
      REG_LPA:   v = lpa;
      REG_ANX:
      begin
        v[ANX_PD_FLT]  = pd_fault;
        v[ANX_LP_ABLE] = lp_able;
      end
      REG_PCS:   v = pcs;
      REG_PHYC:  v = phyc;
      REG_PHYC2: v = phyc2;
      default:   v = 16'h0000;
    endcase
    return v;
  endfunction

  // ------------------------------------------------------------
  // management frame
  // ------------------------------------------------------------
  pac_mf_state_type mf;
  logic [5:0]  pre_cnt;
  logic [3:0]  bit_cnt;
  logic [15:0] sh, rdat;
  logic        own, rd_hit, wr_hit;

  assign own    = (hdr[9:5] == phyc[4:0]);
  assign rd_hit = hdr[12] & (hdr[11:10] == OP_RD) & own;
  assign wr_hit = hdr[12] & (hdr[11:10] == OP_WR)
                  & (own | (hdr[9:5] == ADDR_BC & phyc2[PHYC2_BCAST]));

  // read word follows every register it selects, not only the index
  always_comb
  begin
    rdat = rd_mux(hdr[4:0]);
  end

  // frame sequencer: served in isolate as well
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mf       <= MF_PRE;
      pre_cnt  <= 6'h00;
      bit_cnt  <= 4'h0;
      hdr      <= 13'h0000;
      sh       <= 16'h0000;
      wr_data  <= 16'h0000;
      wr_stb   <= 1'b0;
      rd_stb   <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
    end
    else
    begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (mdc_rise)
      begin
        unique case (mf)
          MF_PRE:
          begin
            if (din)
              pre_cnt <= (pre_cnt == PRE_MIN) ? pre_cnt : pre_cnt + 6'h01;
            else
            begin
              pre_cnt <= 6'h00;
              bit_cnt <= 4'h0;
              if (pre_cnt == PRE_MIN)
                mf <= MF_HDR;
            end
          end
          MF_HDR:
          begin
            hdr     <= {hdr[11:0], din};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == HDR_LAST)
            begin
              bit_cnt <= 4'h0;
              mf      <= MF_TA;
            end
          end
          MF_TA:
          begin
            if (bit_cnt == 4'h0)
            begin
              bit_cnt  <= 4'h1;
              mdio_oe  <= rd_hit;
              mdio_out <= 1'b0;
            end
            else
            begin
              bit_cnt  <= 4'h0;
              mdio_out <= rdat[15];
              sh       <= {rdat[14:0], 1'b0};
              rd_stb   <= rd_hit;
              mf       <= MF_DAT;
            end
          end
          MF_DAT:
          begin
            bit_cnt  <= bit_cnt + 4'h1;
            mdio_out <= sh[15];
            sh       <= {sh[14:0], din};
            if (bit_cnt == DAT_LAST)
            begin
              mdio_oe <= 1'b0;
              pre_cnt <= 6'h00;
              mf      <= MF_PRE;
              wr_stb  <= wr_hit;
              wr_data <= {sh[14:0], din};
            end
          end
          default: mf <= MF_PRE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // negotiation sequencing
  // ------------------------------------------------------------
  logic [26:0] tmr;
  logic        restart, one_link, any_link, act;
  assign any_link = pmd.link10 | pmd.link100;
  assign one_link = pmd.link10 ^ pmd.link100;
  assign act      = any_link | pmd.flp_seen;
  assign restart  = wr_stb & (hdr[4:0] == REG_BMC) & wr_data[BMC_RESTART];

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      an_state <= AN_OFF;
      tmr      <= 27'h0000000;
    end
    else
    begin
      tmr <= tmr + 27'h0000001;
      if (!an_go)
        an_state <= AN_OFF;
      else
        unique case (an_state)
          AN_OFF:
          begin
            an_state <= AN_BRK;
            tmr      <= 27'h0000000;
          end
          AN_BRK:
            if (tmr >= 27'(BRK_CYCLES - 1))
            begin
              an_state <= AN_NEG;
              tmr      <= 27'h0000000;
            end
          AN_NEG:
            if (restart || tmr >= 27'(NEG_CYCLES - 1))
            begin
              an_state <= AN_BRK;
              tmr      <= 27'h0000000;
            end
            else if (pmd.flp_done || (!pmd.flp_seen && one_link))
              an_state <= AN_DONE;
          AN_DONE:
            if (restart || !any_link)
            begin
              an_state <= AN_BRK;
              tmr      <= 27'h0000000;
            end
          default: an_state <= AN_OFF;
        endcase
    end
  end

  // partner ability and expansion status
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lpa      <= 16'h0000;
      lp_able  <= 1'b0;
      pd_fault <= 1'b0;
    end
    else
    begin
      if (an_state == AN_NEG && pmd.flp_done)
      begin
        lpa     <= pmd.flp_word;
        lp_able <= 1'b1;
      end
      else if (an_state == AN_NEG && !pmd.flp_seen && one_link)
      begin
        lpa     <= pmd.link100 ? LP_PD100 : LP_PD10;
        lp_able <= 1'b0;
      end
      // set wins over read clear
      if (an_state == AN_NEG && !pmd.flp_seen && pmd.link10 && pmd.link100)
        pd_fault <= 1'b1;
      else if (rd_stb && hdr[4:0] == REG_ANX)
        pd_fault <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // crossover
  // ------------------------------------------------------------
  logic [7:0]  seed;
  logic [21:0] xo_tmr;
  logic        xo, hunt;
  assign hunt = ~act & ((phyc[PHYC_AUTOX] & an_go)
                        | (pcs[PCS_FXO_EN] & ~an_go));

  // seed runs freely; pair toggles on dwell expiry when the seed says so
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      seed   <= 8'h5A;
      xo_tmr <= 22'h000000;
      xo     <= 1'b0;
    end
    else
    begin
      seed   <= {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      xo_tmr <= xo_tmr + 22'h000001;
      if (xo_tmr >= 22'(XO_CYCLES - 1))
      begin
        xo_tmr <= 22'h000000;
        if (hunt && seed[0])
          xo <= ~xo;
      end
    end
  end

  // ------------------------------------------------------------
  // media outputs
  // ------------------------------------------------------------
  always_comb
  begin
    media.quiet    = (an_state == AN_BRK);
    media.send_flp = (an_state == AN_NEG);
    media.crossed  = phyc[PHYC_FORCEX] | xo;
    media.tx_take  = ~bmc[BMC_ISO];
    media.mii_oe   = ~bmc[BMC_ISO];
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_restart;
    an_state == AN_DONE && an_go && restart |=> an_state == AN_BRK;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missed");

  property p_quiet;
    an_state == AN_BRK |-> media.quiet && !media.send_flp;
  endproperty
  a_quiet: assert property (p_quiet) else $error("not quiet in break");

  property p_pd100;
    an_state == AN_NEG && an_go && !restart && !pmd.flp_done && !pmd.flp_seen
      && pmd.link100 && !pmd.link10 |=> lpa == LP_PD100 && !lp_able;
  endproperty
  a_pd100: assert property (p_pd100) else $error("bad pd partner");

  property p_pdsel;
    an_state == AN_DONE && !lp_able |-> lpa[4:0] == ADDR_DFLT;
  endproperty
  a_pdsel: assert property (p_pdsel) else $error("bad selector");

  property p_fault;
    an_state == AN_NEG && !pmd.flp_seen && pmd.link10 && pmd.link100
      |=> pd_fault ##1 (pd_fault || $past(rd_stb));
  endproperty
  a_fault: assert property (p_fault) else $error("fault not set");

  property p_loss;
    an_state == AN_DONE && an_go && !any_link |=> an_state == AN_BRK && tmr == 27'h0;
  endproperty
  a_loss: assert property (p_loss) else $error("no restart on loss");

  property p_force;
    phyc[PHYC_FORCEX] |-> media.crossed;
  endproperty
  a_force: assert property (p_force) else $error("force ignored");

  property p_iso;
    bmc[BMC_ISO] |-> !media.mii_oe && !media.tx_take;
  endproperty
  a_iso: assert property (p_iso) else $error("isolate leak");

  property p_brk_len;
    $rose(media.quiet) |-> media.quiet [*8];
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break too short");

endmodule
`default_nettype wire

// [test/pac_link_partner.sv]
// remote link partner model for the port control bench
// assumes device media levels on sys_clk; the bench picks the partner mode
`timescale 1ns/1ps
`default_nettype none
module pac_link_partner
  import pac_pkg::*;
#(
  parameter logic [15:0] PAGE = 16'h41E1  // offered base page, plain value
)(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  // 0 silent, 1 negotiating, 2 fixed 100, 3 fixed 10, 4 both links
  input  wire logic [2:0]    mode,
  // device media side
  input  wire pac_media_type media,
  output pac_pmd_type        pmd
);
  logic [3:0] cnt;
  logic       got;

  // ------------------------------------------------------------
  // burst exchange progress
  // ------------------------------------------------------------
  // eight bursts answer the device, link at 100 follows; quiet drops it
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 4'h0;
      got <= 1'b0;
    end
    else
    begin
      if (mode == 3'h1 && media.send_flp)
        cnt <= (cnt == 4'h9) ? cnt : cnt + 4'h1;
      else
        cnt <= 4'h0;
      if (mode != 3'h1 || media.quiet)
        got <= 1'b0;
      else if (pmd.flp_done)
        got <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // line status at the device receivers
  // ------------------------------------------------------------
  // each receiver sees the partner's link at its own speed; both see link only in mode 4
  always_comb
  begin
    pmd.flp_seen = mode == 3'h1 && media.send_flp;
    pmd.flp_done = cnt == 4'h8;
    pmd.flp_word = pmd.flp_done ? PAGE : ~PAGE;  // no stale page outside the pulse
    pmd.link100  = (mode == 3'h1 && got) || mode == 3'h2 || mode == 3'h4;
    pmd.link10   = mode == 3'h3 || mode == 3'h4;
  end
endmodule
`default_nettype wire

// [test/pac_port_ctl_bench.sv]
// self-checking bench for pac_port_ctl: management frames, negotiation,
// crossover, address and isolate behaviour
// assumes pac_pkg and the link partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("[FAIL] %s expected %h seen %h", n, e, g); \
    end \
  end
module pac_port_ctl_bench
  import pac_pkg::*;
;
  localparam int BRK_N = 20;
  localparam int NEG_N = 200;
  localparam int XO_N  = 16;

  logic          sys_clk = 1'b0;
  logic          resetn;
  logic [4:0]    strap;
  logic          an_strap;
  logic          mdc;
  logic          tb_oe;
  logic          tb_bit;
  logic [2:0]    mode;
  logic          mdio_out;
  logic          mdio_oe;
  wire logic     mdio_line;
  pac_pmd_type   pmd;
  pac_media_type media;
  logic [15:0]   r;
  logic          xprev = 1'b0;
  int            fails = 0;
  int            checks = 0;
  int            qcnt = 0;
  int            qlen = 0;
  int            qruns = 0;
  int            xtog = 0;
  int            t;
  int            k;

  // ------------------------------------------------------------
  // clock, pins and instances
  // ------------------------------------------------------------
  always #20 sys_clk = ~sys_clk;

  // mdio has a pull-up: released line reads one
  assign mdio_line = mdio_oe ? mdio_out : (tb_oe ? tb_bit : 1'b1);

  pac_port_ctl #(
    .BRK_CYCLES (BRK_N),
    .NEG_CYCLES (NEG_N),
    .XO_CYCLES  (XO_N)
  ) u_pac_port_ctl (
    .sys_clk            (sys_clk),
    .resetn             (resetn),
    .strap_port_address (strap),
    .strap_an_enable    (an_strap),
    .mdc                (mdc),
    .mdio_in            (mdio_line),
    .mdio_out           (mdio_out),
    .mdio_oe            (mdio_oe),
    .pmd                (pmd),
    .media              (media)
  );

  pac_link_partner u_pac_link_partner (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .mode    (mode),
    .media   (media),
    .pmd     (pmd)
  );

  // ------------------------------------------------------------
  // monitors and management access
  // ------------------------------------------------------------
  // quiet run lengths and crossover changes, sampled mid-cycle
  always @(negedge sys_clk)
  begin
    if (media.quiet === 1'b1)
      qcnt++;
    else if (qcnt != 0)
    begin
      qlen = qcnt;
      qruns++;
      qcnt = 0;
    end
    if (media.crossed !== xprev)
      xtog++;
    xprev = media.crossed;
  end

  // one frame, 10 clocks per mdc period; read data lands in r
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd);
    logic [63:0] v;
    v = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    r = 16'h0000;
    for (int i = 0; i < 66; i++)
    begin
      @(posedge sys_clk);
      mdc    <= 1'b0;
      tb_oe  <= i < 46 || (op == OP_WR && i < 64);
      tb_bit <= i < 64 ? v[63 - i] : 1'b1;
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      if (i >= 48 && i < 64)
        r = {r[14:0], mdio_line};
      @(posedge sys_clk);
      mdc <= 1'b1;
      repeat (4) @(posedge sys_clk);
    end
  endtask

  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
    frame(OP_WR, pa, ra, d);
  endtask

  task automatic rd(input logic [4:0] pa, input logic [4:0] ra);
    frame(OP_RD, pa, ra, 16'h0000);
  endtask

  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    resetn   = 1'b0;
    strap    = 5'h01;
    an_strap = 1'b1;
    mdc      = 1'b0;
    tb_oe    = 1'b0;
    tb_bit   = 1'b1;
    mode     = 3'h1;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    // reset values, break length and partner ability after negotiation
    rd(5'h01, REG_PCS);
    `CHK("pcs", 16'h0000, r)
    rd(5'h01, REG_PHYC);
    `CHK("phyc", 16'h8001, r)
    rd(5'h01, REG_PHYC2);
    `CHK("phyc2", 16'h0000, r)
    `CHK("brk_len", BRK_N, qlen)
    rd(5'h01, REG_ANX);
    `CHK("lp_able", 1'b1, r[0])
    // parallel detect to 100 then 10 after restart
    for (k = 0; k < 2; k++)
    begin
      mode <= k ? 3'h3 : 3'h2;
      repeat (300) @(posedge sys_clk);
      t = qruns;
      wr(5'h01, REG_BMC, 16'h1200);
      repeat (60) @(posedge sys_clk);
      `CHK("restart", t + 1, qruns)
      rd(5'h01, REG_LPA);
      `CHK("lpa", k ? 16'h0021 : 16'h0081, r)
      rd(5'h01, REG_BMS);
      `CHK("done", 1'b1, r[5])
      rd(5'h01, REG_ANX);
      `CHK("pd_able", 1'b0, r[0])
    end
    // link loss, then two links at once
    t = qruns;
    mode <= 3'h0;
    repeat (40) @(posedge sys_clk);
    `CHK("relink", t + 1, qruns)
    `CHK("flp_tx", 1'b1, media.send_flp)
    mode <= 3'h4;
    repeat (100) @(posedge sys_clk);
    rd(5'h01, REG_ANX);
    `CHK("pd_fault", 1'b1, r[4])
    // isolate by register
    mode <= 3'h2;
    wr(5'h01, REG_BMC, 16'h1400);
    `CHK("mii_oe", 1'b0, media.mii_oe)
    `CHK("tx_take", 1'b0, media.tx_take)
    rd(5'h01, REG_LPA);
    `CHK("iso_lpa", 16'h0081, r)
    wr(5'h01, REG_BMC, 16'h1000);
    `CHK("mii_back", 1'b1, media.mii_oe)
    // address matching and broadcast writes
    rd(5'h02, REG_BMC);
    `CHK("foreign", 16'hFFFF, r)
    wr(ADDR_BC, REG_PHYC, 16'hC001);
    rd(5'h01, REG_PHYC);
    `CHK("bc_off", 16'h8001, r)
    wr(5'h01, REG_PHYC2, 16'h0800);
    wr(ADDR_BC, REG_PHYC, 16'hC001);
    rd(5'h01, REG_PHYC);
    `CHK("bc_on", 16'hC001, r)
    `CHK("force_x", 1'b1, media.crossed)
    // strapped address zero, negotiation strapped off
    resetn   <= 1'b0;
    strap    <= 5'h00;
    an_strap <= 1'b0;
    mode     <= 3'h0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (10) @(posedge sys_clk);
    `CHK("strap_iso", 1'b0, media.mii_oe)
    t = qruns;
    wr(5'h00, REG_BMC, 16'h1000);
    repeat (60) @(posedge sys_clk);
    `CHK("unarmed", t, qruns)
    wr(5'h00, REG_PHYC, 16'h0000);
    `CHK("wr_addr0", 1'b1, media.mii_oe)
    // forced-mode crossover hunts, then holds on link
    wr(5'h00, REG_PCS, 16'h8000);
    t = xtog;
    repeat (400) @(posedge sys_clk);
    `CHK("hunt", 1'b1, xtog > t)
    mode <= 3'h3;
    repeat (40) @(posedge sys_clk);
    t = xtog;
    repeat (400) @(posedge sys_clk);
    `CHK("hold", t, xtog)
    // clear then set enable starts negotiation
    t = qruns;
    wr(5'h00, REG_BMC, 16'h0000);
    wr(5'h00, REG_BMC, 16'h1000);
    repeat (60) @(posedge sys_clk);
    `CHK("armed", t + 1, qruns)
    final_report;
  end

  // hang guard, about three times the expected run
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    final_report;
  end
endmodule
`default_nettype wire
